// ===== core/ssi_pkg.sv
// constants shared by the shutter safety interlock
// assumes a 50 MHz system clock and word-aligned register offsets
package ssi_pkg;
	// clock and contact debounce timing
	localparam int CLK_FREQ_MHZ      = 50;
	localparam int DEBOUNCE_TIME_US  = 1000;
	localparam int DEBOUNCE_CYCLES   = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;
	localparam int DEB_CNT_W         = 16;
	localparam int BOOT_LOAD_CYCLE   = 2;

	// register byte offsets
	localparam logic [7:0] REG_MODE   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;

	// command register bits, write-only pulses
	localparam int CMD_FAULT_ACK   = 0;
	localparam int CMD_START       = 1;
	localparam int CMD_SHUT_OPEN   = 2;
	localparam int CMD_SHUT_CLOSE  = 3;
	localparam int CMD_DIODE_ON    = 4;
	localparam int CMD_DIODE_OFF   = 5;

	// status register bits
	localparam int ST_MODE      = 0;
	localparam int ST_RELEASED  = 1;
	localparam int ST_SHUTTER   = 2;
	localparam int ST_DIODE_EN  = 3;
	localparam int ST_DIODE_ON  = 4;
	localparam int ST_INTERLOCK = 5;
	localparam int ST_ESTOP     = 6;
	localparam int ST_LOOP      = 7;
	localparam int ST_ACK_ARMED = 8;
	localparam int ST_KEY       = 9;
	localparam int ST_UC_A      = 10;
	localparam int ST_UC_B      = 11;

	// contact input positions in the synchroniser vector
	localparam int NUM_IN     = 7;
	localparam int IN_UC_A    = 0;
	localparam int IN_UC_B    = 1;
	localparam int IN_START   = 2;
	localparam int IN_KEY     = 3;
	localparam int IN_ESTOP   = 4;
	localparam int IN_LOOP    = 5;
	localparam int IN_NV_MODE = 6;
	// idle levels: start closed, stop released, loop present
	localparam logic [NUM_IN-1:0] DEB_RESET = 7'h34;

	// control modes
	localparam logic MODE_SOFTWARE = 1'b0;
	localparam logic MODE_HARDWARE = 1'b1;

	typedef enum logic [1:0] {
		SSI_LOCKED   = 2'b01,
		SSI_RELEASED = 2'b10
	} ssi_rel_e;
endpackage : ssi_pkg

// ===== core/ssi_interlock.sv
// shutter safety interlock: mode select, contact supervision, release
// assumes contact pins are asynchronous and the mode store is external

module ssi_interlock
	import ssi_pkg::*;
#(
	parameter int DEB_CYCLES = ssi_pkg::DEBOUNCE_CYCLES
)(
	// clock, reset, enable
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic        CE,
	// register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	// contact pins, high when closed or good
	input  wire logic        USER_CONTACT_PAIR_A,
	input  wire logic        USER_CONTACT_PAIR_B,
	input  wire logic        START_BUTTON,
	input  wire logic        KEY_ON,
	input  wire logic        ESTOP_RELEASED,
	input  wire logic        EMISSION_LOOP_OK,
	// non-volatile mode store
	input  wire logic        NV_MODE_IN,
	output logic             NV_MODE_WR,
	output logic             NV_MODE_DATA,
	// safety outputs
	output logic             SHUTTER_OPEN,
	output logic             DIODE_ENABLE,
	output logic             DIODE_ON,
	output logic             EMISSION_LED,
	output logic             START_RELEASED,
	output logic             FAULT
);
	import ssi_pkg::*;

	typedef struct packed {
		logic [NUM_IN-1:0]                s1;
		logic [NUM_IN-1:0]                s2;
		logic [NUM_IN-1:0]                db;
		logic [NUM_IN-1:0][DEB_CNT_W-1:0] cnt;
		logic [1:0]                       boot;
		logic                             loaded;
		logic                             mode;
		logic                             start_prev;
		logic                             both_prev;
		ssi_rel_e                         rel;
		logic                             ack_armed;
		logic                             il;
		logic                             il_open_seen;
		logic                             estop_l;
		logic                             loop_l;
		logic                             shutter;
		logic                             diode_on;
		logic                             nv_wr;
		logic [31:0]                      rdata;
	} ssi_state_s;

	ssi_state_s r;
	ssi_state_s next_r;

	logic        uc_a;
	logic        uc_b;
	logic        both_closed;
	logic        both_open;
	logic        start_edge;
	logic        sys_ok;
	logic        faults;
	logic        cmd_wr;
	logic [31:0] status;

	assign uc_a        = r.db[IN_UC_A];
	assign uc_b        = r.db[IN_UC_B];
	assign both_closed = uc_a && uc_b;
	assign both_open   = !uc_a && !uc_b;
	// level is ignored, a held contact gives no edge after reset
	assign start_edge  = r.db[IN_START] && !r.start_prev;
	assign sys_ok      = r.db[IN_KEY] && r.db[IN_ESTOP] && r.db[IN_LOOP];
	assign faults      = r.il || r.estop_l || r.loop_l;
	assign cmd_wr      = WR && (ADDR == REG_CMD);

	always_comb
	begin
		status               = 32'h0000_0000;
		status[ST_MODE]      = r.mode;
		status[ST_RELEASED]  = (r.rel == SSI_RELEASED);
		status[ST_SHUTTER]   = r.shutter;
		status[ST_DIODE_EN]  = (r.rel == SSI_RELEASED);
		status[ST_DIODE_ON]  = r.diode_on;
		status[ST_INTERLOCK] = r.il;
		status[ST_ESTOP]     = r.estop_l;
		status[ST_LOOP]      = r.loop_l;
		status[ST_ACK_ARMED] = r.ack_armed;
		status[ST_KEY]       = r.db[IN_KEY];
		status[ST_UC_A]      = uc_a;
		status[ST_UC_B]      = uc_b;
	end

	always_comb
	begin
		next_r = r;

		// two flops, then a stability counter per contact
		next_r.s1 = {NV_MODE_IN, EMISSION_LOOP_OK, ESTOP_RELEASED, KEY_ON,
			START_BUTTON, USER_CONTACT_PAIR_B, USER_CONTACT_PAIR_A};
		next_r.s2 = r.s1;
		for (int i = 0; i < NUM_IN; i++)
		begin
			if (r.s2[i] == r.db[i])
				next_r.cnt[i] = '0;
			else if (r.cnt[i] >= DEB_CNT_W'(DEB_CYCLES - 1))
			begin
				next_r.db[i]  = r.s2[i];
				next_r.cnt[i] = '0;
			end
			else
				next_r.cnt[i] = r.cnt[i] + DEB_CNT_W'(1);
		end
		next_r.start_prev = r.db[IN_START];
		next_r.both_prev  = both_closed;

		// stored mode taken once the synchroniser holds it
		if (!r.loaded)
		begin
			next_r.boot = r.boot + 2'd1;
			if (r.boot == 2'(BOOT_LOAD_CYCLE))
			begin
				next_r.mode   = r.s2[IN_NV_MODE];
				next_r.loaded = 1'b1;
			end
		end

		// mode change drops release and writes the store
		next_r.nv_wr = 1'b0;
		if (WR && ADDR == REG_MODE && r.loaded)
		begin
			next_r.mode  = WDATA[0];
			next_r.nv_wr = 1'b1;
			if (WDATA[0] != r.mode)
			begin
				next_r.rel       = SSI_LOCKED;
				next_r.ack_armed = 1'b0;
			end
		end

		// acknowledge: direct in software mode, armed in hardware mode
		if (cmd_wr && WDATA[CMD_FAULT_ACK])
		begin
			if (r.mode == MODE_SOFTWARE)
			begin
				// clear only after open-then-close of both pairs
				if (r.il_open_seen && both_closed)
				begin
					next_r.il           = 1'b0;
					next_r.il_open_seen = 1'b0;
				end
				if (r.db[IN_ESTOP])
					next_r.estop_l = 1'b0;
				if (r.db[IN_LOOP])
					next_r.loop_l = 1'b0;
			end
			else
				next_r.ack_armed = 1'b1;
		end
		// hardware confirmation needs acknowledge, then the button
		if (r.mode == MODE_HARDWARE && r.ack_armed && start_edge)
		begin
			next_r.ack_armed = 1'b0;
			if (r.db[IN_ESTOP])
				next_r.estop_l = 1'b0;
			if (r.db[IN_LOOP])
				next_r.loop_l = 1'b0;
			next_r.il = 1'b0;
		end

		// opening either pair in software mode latches
		if (r.il && both_open)
			next_r.il_open_seen = 1'b1;
		if (r.loaded && r.mode == MODE_SOFTWARE && r.both_prev
			&& !both_closed)
		begin
			next_r.il           = 1'b1;
			next_r.il_open_seen = 1'b0;
		end
		// sets are placed last so an event beats a same-cycle clear
		if (r.loaded && !r.db[IN_ESTOP])
			next_r.estop_l = 1'b1;
		if (r.loaded && !r.db[IN_LOOP])
			next_r.loop_l = 1'b1;

		// release grant, diode enable follows it
		unique case (r.rel)
			SSI_LOCKED:
			begin
				if (r.loaded && sys_ok && !next_r.il && !next_r.estop_l
					&& !next_r.loop_l)
				begin
					if (r.mode == MODE_SOFTWARE && both_closed && cmd_wr
						&& WDATA[CMD_START])
						next_r.rel = SSI_RELEASED;
					if (r.mode == MODE_HARDWARE && both_open && start_edge)
						next_r.rel = SSI_RELEASED;
				end
			end
			SSI_RELEASED:
			begin
				if (!sys_ok || next_r.il || next_r.estop_l || next_r.loop_l)
					next_r.rel = SSI_LOCKED;
				if (r.mode == MODE_SOFTWARE && !both_closed)
					next_r.rel = SSI_LOCKED;
			end
		endcase

		// lasing only by software command once enabled
		if (cmd_wr && WDATA[CMD_DIODE_ON] && r.rel == SSI_RELEASED)
			next_r.diode_on = 1'b1;
		if ((cmd_wr && WDATA[CMD_DIODE_OFF]) || next_r.rel != SSI_RELEASED)
			next_r.diode_on = 1'b0;

		// shutter
		if (r.mode == MODE_SOFTWARE)
		begin
			if (cmd_wr && WDATA[CMD_SHUT_OPEN] && both_closed && !faults)
				next_r.shutter = 1'b1;
			if (cmd_wr && WDATA[CMD_SHUT_CLOSE])
				next_r.shutter = 1'b0;
		end
		else
			next_r.shutter = both_closed;
		// judged on the levels registered now, so no open cycle slips by
		if (next_r.rel != SSI_RELEASED || !both_closed
			|| !next_r.db[IN_UC_A] || !next_r.db[IN_UC_B])
			next_r.shutter = 1'b0;

		// read data in the cycle after the strobe
		next_r.rdata = 32'h0000_0000;
		if (RD)
		begin
			if (ADDR == REG_MODE)
				next_r.rdata = {31'h0000_0000, r.mode};
			else if (ADDR == REG_STATUS)
				next_r.rdata = status;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			// safe start whatever mode is restored
			r              <= '0;
			r.db           <= DEB_RESET;
			r.start_prev   <= 1'b1;
			r.rel          <= SSI_LOCKED;
		end
		else if (CE)
			r <= next_r;
	end

	assign RDATA          = r.rdata;
	assign NV_MODE_WR     = r.nv_wr;
	assign NV_MODE_DATA   = r.mode;
	assign SHUTTER_OPEN   = r.shutter;
	assign DIODE_ENABLE   = (r.rel == SSI_RELEASED);
	assign START_RELEASED = (r.rel == SSI_RELEASED);
	assign DIODE_ON       = r.diode_on;
	// indicator tracks lasing, independent of shutter
	assign EMISSION_LED   = r.diode_on;
	assign FAULT          = faults;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	a_shutter_contacts: assert property (
		SHUTTER_OPEN |-> (uc_a && uc_b && START_RELEASED))
		else $error("shutter open without both contacts closed");
	a_diode_needs_enable: assert property (
		DIODE_ON |-> DIODE_ENABLE)
		else $error("diodes on without enable");
	a_emission_follows: assert property (
		EMISSION_LED == DIODE_ON)
		else $error("emission indicator differs from lasing");
	a_estop_latches: assert property (
		(CE && r.loaded && !r.db[IN_ESTOP]) |=> (r.estop_l && !START_RELEASED))
		else $error("emergency stop did not latch");
	a_loop_error: assert property (
		(CE && r.loaded && !r.db[IN_LOOP]) |=> (FAULT && r.loop_l))
		else $error("missing indicator loop did not raise error");
	a_hw_release_open: assert property (
		($rose(START_RELEASED) && r.mode) |-> $past(both_open))
		else $error("hardware release with contacts not open");
	a_sw_release_closed: assert property (
		($rose(START_RELEASED) && !r.mode) |-> $past(both_closed))
		else $error("software release with contacts not closed");
	a_key_off_locks: assert property (
		(CE && !r.db[IN_KEY]) |=> !START_RELEASED)
		else $error("release kept with key off");
	a_mode_query: assert property (
		(RD && ADDR == REG_MODE && CE) |=> (RDATA == {31'h0, $past(r.mode)}))
		else $error("mode query answered wrongly");
	a_reset_safe: assert property (
		$past(RST) |-> (!SHUTTER_OPEN && !DIODE_ENABLE && !DIODE_ON))
		else $error("unsafe outputs after reset");
	a_diode_on_cmd: assert property (
		$rose(DIODE_ON) |-> $past(cmd_wr && WDATA[CMD_DIODE_ON]))
		else $error("diodes on without software command");
	a_sw_shutter_cmd: assert property (
		($rose(SHUTTER_OPEN) && !$past(r.mode))
		|-> $past(cmd_wr && WDATA[CMD_SHUT_OPEN] && !faults))
		else $error("software mode shutter opened without command");
	a_sys_ok_release: assert property (
		(CE && !sys_ok) |=> !START_RELEASED)
		else $error("release kept without key, stop and loop");
	a_sw_interlock_set: assert property (
		(CE && r.loaded && !r.mode && r.both_prev && !both_closed)
		|=> FAULT)
		else $error("opened contact did not latch interlock");
	a_hw_ack_needed: assert property (
		($fell(r.estop_l) && $past(r.mode) && !$past(RST))
		|-> $past(r.ack_armed && start_edge))
		else $error("hardware stop latch cleared without confirmation");
endmodule : ssi_interlock

// ===== tb/ssi_contacts_model.sv
// customer safety circuit contacts and the non-volatile mode store
// assumes the bench calls its tasks; contacts change after a rising edge
module ssi_contacts_model #(
	parameter int SETTLE = 12
)(
	// clock
	input  wire logic clk,
	// mode store
	input  wire logic nv_wr,
	input  wire logic nv_data,
	output logic      nv_mode,
	// contacts, high when closed or good
	output logic      uc_a,
	output logic      uc_b,
	output logic      start_btn,
	output logic      key_on,
	output logic      estop_ok,
	output logic      loop_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	// store keeps its value across a reset of the block
	initial
	begin
		nv_mode = 1'b0;
		uc_a = 1'b0;
		uc_b = 1'b0;
		start_btn = 1'b1; // held closed from power-on
		key_on = 1'b1;
		estop_ok = 1'b1;
		loop_ok = 1'b1;
	end
	always @(posedge clk)
		if (nv_wr)
			nv_mode <= nv_data;
	task automatic set_uc(input logic a, input logic b);
		@(posedge clk);
		uc_a <= a;
		uc_b <= b;
		repeat (SETTLE) @(posedge clk);
	endtask : set_uc
	// both pairs opened, then closed again
	task automatic cycle_uc();
		set_uc(1'b0, 1'b0);
		set_uc(1'b1, 1'b1);
	endtask : cycle_uc
	task automatic set_sys(input logic k, input logic e, input logic l);
		@(posedge clk);
		key_on <= k;
		estop_ok <= e;
		loop_ok <= l;
		repeat (SETTLE) @(posedge clk);
	endtask : set_sys
	// a press always opens first, so a held contact counts
	task automatic press();
		@(posedge clk);
		start_btn <= 1'b0;
		repeat (SETTLE) @(posedge clk);
		start_btn <= 1'b1;
		repeat (SETTLE) @(posedge clk);
	endtask : press
endmodule : ssi_contacts_model

// ===== tb/ssi_interlock_tb.sv
// self-checking bench for the shutter safety interlock
// assumes a short debounce parameter and the contact model beside it
module ssi_interlock_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ssi_pkg::*;
	localparam int DEB = 4;
	localparam int SET = DEB + 8;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic        uc_a, uc_b, start_btn, key_on, estop_ok, loop_ok, nv_in;
	logic        nv_wr, nv_data, shut, den, don, led, rel, fault;
	int          n_mismatch = 0;
	int          num_checks = 0;
	always #10 clk_sys = ~clk_sys;
	ssi_interlock #(.DEB_CYCLES(DEB)) u_ssi_interlock (
		.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.USER_CONTACT_PAIR_A(uc_a), .USER_CONTACT_PAIR_B(uc_b),
		.START_BUTTON(start_btn), .KEY_ON(key_on),
		.ESTOP_RELEASED(estop_ok), .EMISSION_LOOP_OK(loop_ok),
		.NV_MODE_IN(nv_in), .NV_MODE_WR(nv_wr), .NV_MODE_DATA(nv_data),
		.SHUTTER_OPEN(shut), .DIODE_ENABLE(den), .DIODE_ON(don),
		.EMISSION_LED(led), .START_RELEASED(rel), .FAULT(fault));
	ssi_contacts_model #(.SETTLE(SET)) u_ssi_contacts_model (
		.clk(clk_sys), .nv_wr(nv_wr), .nv_data(nv_data), .nv_mode(nv_in),
		.uc_a(uc_a), .uc_b(uc_b), .start_btn(start_btn),
		.key_on(key_on), .estop_ok(estop_ok), .loop_ok(loop_ok));
	task automatic chk(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", what, e, g);
		end
	endtask : chk
	task automatic chk_word(input string what, input logic [31:0] e);
		num_checks++;
		if (d !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, d);
		end
	endtask : chk_word
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg
	task automatic cmd(input int b);
		wr_reg(REG_CMD, 32'h1 << b);
	endtask : cmd
	task automatic do_reset();
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (SET) @(posedge clk_sys);
		#1;
	endtask : do_reset
	task automatic t_reset(input logic [31:0] m);
		do_reset();
		chk("shutter", 1'b0, shut);
		chk("release", 1'b0, rel);
		chk("diode en", 1'b0, den);
		rd_reg(REG_MODE);
		chk_word("mode", m);
		rd_reg(8'h0C);
		chk_word("unmapped", 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_sw();
		cmd(CMD_START);
		chk("release", 1'b0, rel);
		u_ssi_contacts_model.set_uc(1'b1, 1'b1);
		cmd(CMD_START);
		chk("diode en", 1'b1, den);
		cmd(CMD_SHUT_OPEN);
		chk("shutter", 1'b1, shut);
		cmd(CMD_DIODE_ON);
		chk("led", 1'b1, led);
		cmd(CMD_SHUT_CLOSE);
		chk("led", 1'b1, led);
		cmd(CMD_DIODE_OFF);
		chk("diode on", 1'b0, don);
		cmd(CMD_SHUT_OPEN);
		u_ssi_contacts_model.set_uc(1'b0, 1'b1);
		chk("shutter", 1'b0, shut);
		chk("fault", 1'b1, fault);
		u_ssi_contacts_model.set_uc(1'b1, 1'b1);
		cmd(CMD_FAULT_ACK);
		chk("fault", 1'b1, fault);
		u_ssi_contacts_model.cycle_uc();
		cmd(CMD_FAULT_ACK);
		chk("fault", 1'b0, fault);
		$display("test software mode done");
	endtask : t_sw
	task automatic t_hw();
		u_ssi_contacts_model.set_uc(1'b0, 1'b0);
		wr_reg(REG_MODE, 32'h1);
		chk("stored", 1'b1, nv_in);
		chk("release", 1'b0, rel);
		// interlock latched while the pairs opened in software mode
		cmd(CMD_FAULT_ACK);
		u_ssi_contacts_model.press();
		chk("fault", 1'b0, fault);
		chk("diode en", 1'b1, den);
		chk("diode on", 1'b0, don);
		@(posedge clk_sys);
		ce <= 1'b0;
		cmd(CMD_DIODE_ON);
		chk("frozen", 1'b0, don);
		@(posedge clk_sys);
		ce <= 1'b1;
		cmd(CMD_DIODE_ON);
		chk("diode on", 1'b1, don);
		u_ssi_contacts_model.set_uc(1'b1, 1'b1);
		chk("shutter", 1'b1, shut);
		u_ssi_contacts_model.set_uc(1'b1, 1'b0);
		chk("shutter", 1'b0, shut);
		u_ssi_contacts_model.set_sys(1'b0, 1'b1, 1'b1);
		chk("release", 1'b0, rel);
		chk("diode on", 1'b0, don);
		u_ssi_contacts_model.set_sys(1'b1, 1'b1, 1'b1);
		u_ssi_contacts_model.press();
		chk("release", 1'b0, rel);
		$display("test hardware mode done");
	endtask : t_hw
	task automatic t_fault();
		u_ssi_contacts_model.set_uc(1'b0, 1'b0);
		u_ssi_contacts_model.press();
		u_ssi_contacts_model.set_sys(1'b1, 1'b0, 1'b1);
		chk("release", 1'b0, rel);
		u_ssi_contacts_model.set_sys(1'b1, 1'b1, 1'b1);
		chk("fault", 1'b1, fault);
		u_ssi_contacts_model.press();
		chk("fault", 1'b1, fault);
		cmd(CMD_FAULT_ACK);
		u_ssi_contacts_model.press();
		chk("fault", 1'b0, fault);
		chk("release", 1'b1, rel);
		u_ssi_contacts_model.set_sys(1'b1, 1'b1, 1'b0);
		chk("fault", 1'b1, fault);
		chk("release", 1'b0, rel);
		$display("test faults done");
	endtask : t_fault
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	// the whole run needs about 460 cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		t_reset(32'h0);
		t_sw();
		t_hw();
		t_fault();
		u_ssi_contacts_model.set_sys(1'b1, 1'b1, 1'b1);
		t_reset(32'h1);
		end_of_test();
	end
endmodule : ssi_interlock_tb
